/* File: rtl/clpc_top.sv */
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// RL1: After reset the processor runs from the internal 8 MHz RC.
// RL2: A selected external 4-32 MHz clock is watched all the while in use.
// RL3: A failed external clock hands the system back to the internal RC.
// RL4: A clock failure raises the interrupt only when its mask bit is set.
// RL5: A failure seen on the PLL input path also raises an interrupt.
// RL6: Prescalers derive bus clocks, each kept at or below 48 MHz.
// RL7: Sleep halts only the processor clock and any interrupt resumes it.
// RL8: Stop gates all core clocks and disables PLL, RC and crystal.
// RL9: Any enabled line of the 19 wake sources leaves Stop mode.
// RL10: Stop leaves the real-time clock, watchdog and their clocks running.
// RL11: The outside circuit holds the power-on reset pin low until stable.
// RL12: The failure flag stays set after fallback until software clears it.
module clpc_top
   import clpc_pkg::*;
#(
   parameter int MON_GAP = CLPC_MON_GAP_CYC
) (
   input  wire logic        clk_i,            // 40 MHz system clock
   input  wire logic        reset_n_i,        // Async reset, active low
   input  wire logic        power_on_reset_pin_i, // Reset pin level
   input  wire logic        ext_osc_clk_i,    // External clock, raw pin
   input  wire logic        pll_in_fail_i,    // PLL input loss, async
   input  wire logic [18:0] wake_src_i,       // Event lines, async
   input  wire logic        periph_irq_i,     // Any peripheral event
   input  wire logic [7:0]  addr_i,           // Register byte address
   input  wire logic [31:0] wdata_i,          // Write data
   input  wire logic        wr_i,             // Write strobe
   input  wire logic        rd_i,             // Read strobe
   output logic      [31:0] rdata_o,          // Read data, next cycle
   output logic             irq_o,            // Level interrupt
   output clpc_src_t        sys_src_o,        // Selected clock source
   output logic             cpu_clk_en_o,     // Processor clock gate
   output logic             core_clk_en_o,    // Core domain clock gate
   output logic             int_rc_en_o,      // Internal RC enable
   output logic             ext_osc_en_o,     // Crystal enable
   output logic             pll_en_o,         // PLL enable
   output logic             lsclk_keep_o,     // RTC and watchdog clocks
   output logic      [3:0]  ahb_div_o,        // AHB log2 divide
   output logic      [3:0]  apb_div_o,        // APB log2 divide
   output logic             chip_reset_o      // Holds chip in reset
);

   logic [2:0]  ctrl_q;
   clpc_presc_t presc_q;
   logic [18:0] wake_en_q;
   logic [CLPC_IRQ_W-1:0] ist_q;
   logic [CLPC_IRQ_W-1:0] imk_q;
   logic        fail_q;
   clpc_pwr_t   pwr_q;
   clpc_src_t   src_q;
   logic [2:0]  ext_sync_q;
   logic [2:0]  pll_sync_q;
   logic [2:0]  por_sync_q;
   logic [18:0] wk_s1_q;
   logic [18:0] wk_s2_q;
   logic [18:0] wk_s3_q;
   logic        ext_lvl_q;
   logic        pll_lvl_q;
   logic        por_lvl_q;
   logic [18:0] wk_lvl_q;
   logic [15:0] gap_q;
   logic        fail_ev;
   logic        pll_ev;
   logic        wake_ev;
   logic        wr_ctrl;
   logic        rd_ist;
   logic        cmd_sleep;
   logic        cmd_stop;

   // Rate check on one bus clock; a slip here would overclock a bus
   function automatic logic [3:0] clpc_div_ok(input logic [3:0] d);
      if (CLPC_CLK_MHZ <= CLPC_BUS_MAX_MHZ) begin
         return d;
      end
      return (d == 4'h0) ? 4'h1 : d;
   endfunction

   // Exact byte-address match for one register strobe
   function automatic logic clpc_hit(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] ofs);
      return strobe && (addr == ofs);
   endfunction

   // Strobe decodes shared by several processes
   assign wr_ctrl   = clpc_hit(wr_i, addr_i, CLPC_CTRL_OFS);
   assign rd_ist    = clpc_hit(rd_i, addr_i, CLPC_IRQ_ST_OFS);
   assign cmd_sleep = clpc_hit(wr_i, addr_i, CLPC_LOWP_OFS)
                      && (wdata_i[1:0] == CLPC_CMD_SLEEP);
   assign cmd_stop  = clpc_hit(wr_i, addr_i, CLPC_LOWP_OFS)
                      && (wdata_i[1:0] == CLPC_CMD_STOP);

   // Crystal synchroniser; stages two and three feed decisions
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_sync_q <= 3'h0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ext_osc_clk_i};
      end
   end

   // PLL input failure synchroniser
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pll_sync_q <= 3'h0;
      end else begin
         pll_sync_q <= {pll_sync_q[1:0], pll_in_fail_i};
      end
   end

   // Reset pin synchroniser; clears to the held-in-reset level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         por_sync_q <= 3'h0;
      end else begin
         por_sync_q <= {por_sync_q[1:0], power_on_reset_pin_i};
      end
   end

   // Wake line synchronisers, one chain of three per line
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wk_s1_q <= 19'h00000;
         wk_s2_q <= 19'h00000;
         wk_s3_q <= 19'h00000;
      end else begin
         wk_s1_q <= wake_src_i;
         wk_s2_q <= wk_s1_q;
         wk_s3_q <= wk_s2_q;
      end
   end

   // Crystal level moves only when stages two and three agree
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_lvl_q <= 1'b0;
      end else if (ext_sync_q[1] == ext_sync_q[2]) begin
         ext_lvl_q <= ext_sync_q[2];
      end
   end

   // PLL failure level; reset matches the idle pin, so no false edge
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pll_lvl_q <= 1'b0;
      end else if (pll_sync_q[1] == pll_sync_q[2]) begin
         pll_lvl_q <= pll_sync_q[2];
      end
   end

   // Reset pin level; starts low so the chip stays held until
   // the pin has been seen high on two samples
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         por_lvl_q <= 1'b0;
      end else if (por_sync_q[1] == por_sync_q[2]) begin
         por_lvl_q <= por_sync_q[2];
      end
   end

   // Wake lines filtered bit by bit; a glitch shorter than two
   // samples never reaches the Stop exit
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wk_lvl_q <= 19'h00000;
      end else begin
         for (int i = 0; i < 19; i++) begin
            if (wk_s2_q[i] == wk_s3_q[i]) begin
               wk_lvl_q[i] <= wk_s3_q[i];
            end
         end
      end
   end

   // RL11 reset pin low keeps the chip held
   assign chip_reset_o = !por_lvl_q;

   // Control word, always written whole
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= CLPC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= wdata_i[2:0];
      end
   end

   // Bus prescaler setting
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         presc_q <= CLPC_PRESC_RST;
      end else if (clpc_hit(wr_i, addr_i, CLPC_PRESC_OFS)) begin
         presc_q <= wdata_i[7:0];
      end
   end

   // Wake enables; all sources armed after reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wake_en_q <= CLPC_WAKE_RST;
      end else if (clpc_hit(wr_i, addr_i, CLPC_WAKE_OFS)) begin
         wake_en_q <= wdata_i[18:0];
      end
   end

   // Interrupt mask, same layout as the status word
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         imk_q <= '0;
      end else if (clpc_hit(wr_i, addr_i, CLPC_IRQ_MK_OFS)) begin
         imk_q <= wdata_i[CLPC_IRQ_W-1:0];
      end
   end

   // RL2 edge-gap watchdog on the external clock while it is in use
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap_q <= 16'h0000;
      end else if (!(ctrl_q[CLPC_CTRL_MON_EN] && src_q == CLPC_SRC_EXT)
                   || (ext_lvl_q != ext_sync_q[2]
                       && ext_sync_q[1] == ext_sync_q[2])) begin
         gap_q <= 16'h0000;
      end else if (gap_q != 16'hffff) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   assign fail_ev = ctrl_q[CLPC_CTRL_MON_EN] && (src_q == CLPC_SRC_EXT)
                    && (gap_q == 16'(MON_GAP));
   // RL5 rising failure on the PLL input path
   assign pll_ev  = pll_sync_q[1] && pll_sync_q[2] && !pll_lvl_q;
   assign wake_ev = |(wk_lvl_q & wake_en_q) && (pwr_q == CLPC_STOP);

   // RL1 internal RC after reset; RL3 automatic fallback on failure
   // A select is judged on the written word, since the old control
   // value would still show the crystal disabled in that cycle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         src_q <= CLPC_SRC_INT_RC;
      end else if (fail_ev) begin
         src_q <= CLPC_SRC_INT_RC;
      end else if (wr_ctrl) begin
         if (wdata_i[CLPC_CTRL_SEL_EXT] && wdata_i[CLPC_CTRL_EXT_EN]
             && !fail_q) begin
            src_q <= CLPC_SRC_EXT;
         end else begin
            src_q <= CLPC_SRC_INT_RC;
         end
      end else if (!ctrl_q[CLPC_CTRL_EXT_EN]) begin
         src_q <= CLPC_SRC_INT_RC;
      end
   end

   // RL12 failure flag held until cleared through the control write
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fail_q <= 1'b0;
      end else if (fail_ev) begin
         fail_q <= 1'b1;
      end else if (wr_ctrl && !wdata_i[CLPC_CTRL_SEL_EXT]) begin
         fail_q <= 1'b0;
      end
   end

   // RL4 sticky events; a new event beats the clear-on-read
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ist_q <= '0;
      end else begin
         ist_q <= (rd_ist ? '0 : ist_q)
                  | {wake_ev, pll_ev, fail_ev};
      end
   end

   assign irq_o = |(ist_q & imk_q);

   // RL7 Sleep resumes on interrupt; RL9 Stop ends on enabled wake line
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwr_q <= CLPC_RUN;
      end else begin
         case (pwr_q)
            CLPC_RUN: begin
               if (cmd_stop) begin
                  pwr_q <= CLPC_STOP;
               end else if (cmd_sleep) begin
                  pwr_q <= CLPC_SLEEP;
               end
            end
            CLPC_SLEEP: begin
               if (periph_irq_i || irq_o) begin
                  pwr_q <= CLPC_RUN;
               end
            end
            CLPC_STOP: begin
               if (|(wk_lvl_q & wake_en_q)) begin
                  pwr_q <= CLPC_RUN;
               end
            end
            default: pwr_q <= CLPC_RUN;
         endcase
      end
   end

   // RL8 clocks and oscillators off in Stop; RL7 only cpu gated in Sleep
   assign cpu_clk_en_o  = (pwr_q == CLPC_RUN);
   assign core_clk_en_o = (pwr_q != CLPC_STOP);
   assign int_rc_en_o   = (pwr_q != CLPC_STOP);
   assign ext_osc_en_o  = (pwr_q != CLPC_STOP) && ctrl_q[CLPC_CTRL_EXT_EN];
   assign pll_en_o      = 1'b0;
   // RL10 low-speed clocks never stopped by Stop
   assign lsclk_keep_o  = 1'b1;
   assign sys_src_o     = src_q;
   // RL6 bus dividers applied through the rate check
   assign ahb_div_o     = clpc_div_ok(presc_q.ahb_div);
   assign apb_div_o     = clpc_div_ok(presc_q.apb_div);

   // Read port, data valid the cycle after the strobe
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            CLPC_CTRL_OFS:   rdata_o <= {29'h0, ctrl_q};
            CLPC_STATUS_OFS: rdata_o <= {26'h0, pwr_q == CLPC_STOP,
                                         pwr_q == CLPC_SLEEP,
                                         fail_q, ext_lvl_q, src_q};
            CLPC_IRQ_ST_OFS: rdata_o <= {29'h0, ist_q};
            CLPC_IRQ_MK_OFS: rdata_o <= {29'h0, imk_q};
            CLPC_PRESC_OFS:  rdata_o <= {24'h0, presc_q};
            CLPC_WAKE_OFS:   rdata_o <= {13'h0, wake_en_q};
            default:         rdata_o <= 32'h00000000;
         endcase
      end else begin
         rdata_o <= 32'h00000000;
      end
   end

endmodule

/* File: rtl/clpc_pkg.sv */
package clpc_pkg;

   // Register map (byte addresses, one aligned word each)
   localparam logic [7:0] CLPC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] CLPC_STATUS_OFS = 8'h04;
   localparam logic [7:0] CLPC_IRQ_ST_OFS = 8'h08;
   localparam logic [7:0] CLPC_IRQ_MK_OFS = 8'h0c;
   localparam logic [7:0] CLPC_PRESC_OFS  = 8'h10;
   localparam logic [7:0] CLPC_WAKE_OFS   = 8'h14;
   localparam logic [7:0] CLPC_LOWP_OFS   = 8'h18;

   // Control register fields
   localparam int CLPC_CTRL_EXT_EN  = 0;
   localparam int CLPC_CTRL_SEL_EXT = 1;
   localparam int CLPC_CTRL_MON_EN  = 2;

   // Interrupt status bit positions
   localparam int CLPC_IRQ_FAIL = 0;
   localparam int CLPC_IRQ_PLL  = 1;
   localparam int CLPC_IRQ_WAKE = 2;
   localparam int CLPC_IRQ_W    = 3;

   // Values after reset
   localparam logic [2:0]  CLPC_CTRL_RST  = 3'h0;
   localparam logic [7:0]  CLPC_PRESC_RST = 8'h00;
   localparam logic [18:0] CLPC_WAKE_RST  = 19'h7ffff;

   // Low-power command codes
   localparam logic [1:0] CLPC_CMD_SLEEP = 2'h1;
   localparam logic [1:0] CLPC_CMD_STOP  = 2'h2;

   // Clock and monitor timing
   localparam int CLPC_CLK_MHZ      = 40;
   localparam int CLPC_BUS_MAX_MHZ  = 48;
   localparam int CLPC_INT_RC_MHZ   = 8;
   localparam int CLPC_EXT_MIN_MHZ  = 4;
   // Longest allowed gap between external clock edges, in ns
   localparam int CLPC_MON_GAP_NS   = 500;
   localparam int CLPC_MON_GAP_CYC  =
      (CLPC_MON_GAP_NS * CLPC_CLK_MHZ) / 1000;

   typedef enum logic [1:0] {
      CLPC_SRC_INT_RC,
      CLPC_SRC_EXT,
      CLPC_SRC_PLL
   } clpc_src_t;

   typedef enum {
      CLPC_RUN,
      CLPC_SLEEP,
      CLPC_STOP
   } clpc_pwr_t;

   // Bus prescaler setting, log2 divide factors
   typedef struct packed {
      logic [3:0] ahb_div;
      logic [3:0] apb_div;
   } clpc_presc_t;

   // Wake sources: 16 external lines, rtc, two-wire, serial
   typedef struct packed {
      logic        serial_port_one;
      logic        two_wire_port_one;
      logic        rtc;
      logic [15:0] lines;
   } clpc_wake_t;

endpackage

/* File: verification/clpc_ext_model.sv */
`timescale 1ns/1ps
// Crystal source and reset pin seen from outside the chip
module clpc_ext_model #(
   parameter realtime HALF = 55.0 // Slow 9.1 MHz; any 4-32 MHz works
) (
   input  wire logic osc_en_i,  // Crystal enable
   input  wire logic dead_i,    // Crystal failure
   input  wire logic por_low_i, // Hold reset pin low
   output logic      osc_clk_o, // Crystal output
   output logic      por_pin_o  // Reset pin level
);
   initial begin
      osc_clk_o = 1'h0;
      forever begin
         #(HALF);
         if (osc_en_i && !dead_i) begin
            osc_clk_o = ~osc_clk_o;
         end
      end
   end
   assign por_pin_o = por_low_i ? 1'h0 : 1'h1;
endmodule

/* File: verification/clpc_asserts.sv */
`timescale 1ns/1ps
module clpc_asserts
   import clpc_pkg::*;
#(
   parameter int MON_GAP = 20
) (
   input wire logic        clk_i,         // Clock
   input wire logic        reset_n_i,     // Reset
   input wire logic        power_on_reset_pin_i, // Pin
   input wire logic        ext_osc_clk_i, // Crystal
   input wire logic [18:0] wake_src_i,    // Wake lines
   input wire logic        periph_irq_i,  // Event
   input wire logic [7:0]  addr_i,        // Address
   input wire logic [31:0] wdata_i,       // Data
   input wire logic        wr_i,          // Write
   input wire logic        irq_o,         // Interrupt
   input wire clpc_src_t   sys_src_o,     // Source
   input wire logic        cpu_clk_en_o,  // Cpu gate
   input wire logic        core_clk_en_o, // Core gate
   input wire logic        int_rc_en_o,   // RC on
   input wire logic        ext_osc_en_o,  // Crystal on
   input wire logic        pll_en_o,      // PLL on
   input wire logic        lsclk_keep_o,  // Slow clocks
   input wire logic        chip_reset_o   // Chip reset
);
   logic        ext_q;
   logic        mon_q;
   logic [15:0] gap_q;
   logic [18:0] wen_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // Shadow of monitor and wake enables, and the silent-crystal count
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_q <= 1'h0;
         mon_q <= 1'h0;
         gap_q <= 16'h0;
         wen_q <= CLPC_WAKE_RST;
      end else begin
         ext_q <= ext_osc_clk_i;
         if (wr_i && addr_i == CLPC_CTRL_OFS) begin
            mon_q <= wdata_i[CLPC_CTRL_MON_EN];
         end
         if (wr_i && addr_i == CLPC_WAKE_OFS) begin
            wen_q <= wdata_i[18:0];
         end
         if (sys_src_o == CLPC_SRC_EXT && mon_q && ext_q == ext_osc_clk_i) begin
            gap_q <= gap_q + 16'h1;
         end else begin
            gap_q <= 16'h0;
         end
      end
   end

   rc_boot_a: assert property (
      $rose(reset_n_i) |-> sys_src_o == CLPC_SRC_INT_RC && int_rc_en_o)
      else $error("source after reset is not the internal RC");
   mon_gap_a: assert property (gap_q <= MON_GAP + 8)
      else $error("silent crystal kept as source");
   fall_back_a: assert property (
      $past(sys_src_o) == CLPC_SRC_EXT |->
         sys_src_o inside {CLPC_SRC_EXT, CLPC_SRC_INT_RC})
      else $error("crystal source left for other than RC");
   irq_mask_a: assert property (
      wr_i && addr_i == CLPC_IRQ_MK_OFS && wdata_i[2:0] == 3'h0 |=> !irq_o)
      else $error("interrupt high with all masked");
   sleep_wake_a: assert property (
      core_clk_en_o && !cpu_clk_en_o && periph_irq_i |-> ##[1:3] cpu_clk_en_o)
      else $error("sleep not left on event");
   stop_gate_a: assert property (
      !core_clk_en_o |-> !int_rc_en_o && !ext_osc_en_o && !cpu_clk_en_o)
      else $error("oscillator running in stop");
   stop_wake_a: assert property (
      !core_clk_en_o && |(wake_src_i & wen_q) |-> ##[1:8] core_clk_en_o)
      else $error("stop not left on wake line");
   keep_clk_a: assert property (lsclk_keep_o && !pll_en_o)
      else $error("slow clocks dropped");
   por_hold_a: assert property (
      !power_on_reset_pin_i [*5] |-> chip_reset_o)
      else $error("chip left reset with pin low");
endmodule

bind clpc_top clpc_asserts #(.MON_GAP(MON_GAP)) clpc_asserts_inst (.*);

/* File: verification/clpc_top_bench.sv */
`timescale 1ns/1ps
module clpc_top_bench;
   import clpc_pkg::*;
   localparam int GAP = 8;
   logic        clk_i = 1'h0, reset_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
   logic        pll_in_fail_i = 1'h0, periph_irq_i = 1'h0;
   logic        dead = 1'h0, por_low = 1'h0, t_end;
   logic        power_on_reset_pin_i, ext_osc_clk_i, irq_o, pll_en_o;
   logic        cpu_clk_en_o, core_clk_en_o, int_rc_en_o, ext_osc_en_o;
   logic        lsclk_keep_o, chip_reset_o;
   logic [18:0] wake_src_i = 19'h0;
   logic [7:0]  addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, v, r;
   logic [3:0]  ahb_div_o, apb_div_o;
   clpc_src_t   sys_src_o;
   int          err_total = 0, n_tests = 0, k, t;

   clpc_top #(.MON_GAP(GAP)) clpc_top_inst (.*);
   clpc_ext_model clpc_ext_model_inst (
      .osc_en_i  (ext_osc_en_o),
      .dead_i    (dead),
      .por_low_i (por_low),
      .osc_clk_o (ext_osc_clk_i),
      .por_pin_o (power_on_reset_pin_i)
   );

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic cy(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'h1;
      @(posedge clk_i);
      wr_i    <= 1'h0;
   endtask
   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'h1;
      @(posedge clk_i);
      rd_i   <= 1'h0;
      #1 v = rdata_o;
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   function automatic logic irq_exp(input logic [2:0] st, mk);
      return |(st & mk);
   endfunction
   task automatic finish_test;
      $display("Checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Whole run is under a thousand cycles
   initial begin
      #60000;
      err_total++;
      finish_test();
   end

   initial begin
      void'($urandom(12));
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'h1;
      cy(6);
      chk("src", CLPC_SRC_INT_RC, sys_src_o);
      chk("chip_rst", 1'h0, chip_reset_o);
      rd(CLPC_WAKE_OFS);
      chk("wake_rst", 32'h7ffff, v);
      rd(8'h1c);
      chk("unmapped", 32'h0, v);
      for (k = 0; k < 4; k++) begin
         r = $urandom & 32'hff;
         wr(CLPC_PRESC_OFS, r);
         cy(1);
         chk("ahb", r[7:4], ahb_div_o);
         chk("apb", r[3:0], apb_div_o);
      end
      // Crystal selected, then killed under the monitor
      wr(CLPC_IRQ_MK_OFS, 32'h1);
      wr(CLPC_CTRL_OFS, 32'h7);
      cy(2 * GAP);
      chk("src_ext", CLPC_SRC_EXT, sys_src_o);
      dead <= 1'h1;
      cy(GAP + 10);
      chk("fallback", CLPC_SRC_INT_RC, sys_src_o);
      chk("fail_irq", irq_exp(3'h1, 3'h1), irq_o);
      wr(CLPC_CTRL_OFS, 32'h7);
      rd(CLPC_STATUS_OFS);
      chk("flag", 32'h8, v & 32'hb);
      rd(CLPC_IRQ_ST_OFS);
      chk("fail_st", 32'h1, v);
      chk("irq_clr", 1'h0, irq_o);
      wr(CLPC_CTRL_OFS, 32'h1);
      rd(CLPC_STATUS_OFS);
      chk("flag_clr", 32'h0, v & 32'hb);
      dead <= 1'h0;
      // Masked then unmasked input-path event
      wr(CLPC_IRQ_MK_OFS, 32'h0);
      @(posedge clk_i) pll_in_fail_i <= 1'h1;
      cy(6);
      chk("pll_mask", irq_exp(3'h2, 3'h0), irq_o);
      wr(CLPC_IRQ_MK_OFS, 32'h2);
      cy(1);
      chk("pll_irq", irq_exp(3'h2, 3'h2), irq_o);
      rd(CLPC_IRQ_ST_OFS);
      chk("pll_st", 32'h2, v);
      @(posedge clk_i) pll_in_fail_i <= 1'h0;
      wr(CLPC_LOWP_OFS, {30'h0, CLPC_CMD_SLEEP});
      cy(1);
      chk("slp_cpu", 2'h1, {cpu_clk_en_o, core_clk_en_o});
      @(posedge clk_i) periph_irq_i <= 1'h1;
      cy(3);
      periph_irq_i <= 1'h0;
      chk("slp_wake", 1'h1, cpu_clk_en_o);
      // Each wake source alone; the others high but disabled
      for (k = 0; k < 19; k++) begin
         wr(CLPC_WAKE_OFS, 32'h1 << k);
         @(posedge clk_i) wake_src_i <= ~(19'h1 << k);
         wr(CLPC_LOWP_OFS, {30'h0, CLPC_CMD_STOP});
         cy(8);
         chk("stop_core", 2'h0, {core_clk_en_o, cpu_clk_en_o});
         chk("stop_osc", 3'h0, {int_rc_en_o, ext_osc_en_o, pll_en_o});
         chk("stop_keep", 1'h1, lsclk_keep_o);
         @(posedge clk_i) wake_src_i <= 19'h7ffff;
         for (t = 0; t < 10 && core_clk_en_o !== 1'h1; t++) cy(1);
         chk("stop_wake", 1'h1, core_clk_en_o);
         @(posedge clk_i) wake_src_i <= 19'h0;
      end
      por_low <= 1'h1;
      cy(6);
      chk("por_hold", 1'h1, chip_reset_o);
      por_low <= 1'h0;
      cy(6);
      chk("por_rel", 1'h0, chip_reset_o);
      finish_test();
   end
endmodule
